// File: hdl/mqpa_pkg.sv
package mqpa_pkg;
	localparam int DATA_W = 36;
	localparam int QN = 4;
	localparam int QW = 2;
	localparam int DEPTH = 16;
	localparam int PTR_W = 4;
	localparam int CNT_W = 5;
	localparam int WADDR_W = 5;
	localparam int RADDR_W = 6;
	localparam int ID_W = 3;
	localparam int RADDR_NULL_BIT = 2;
	localparam int UNIT9_W = 9;
	localparam int UNIT18_W = 18;

	localparam logic [CNT_W-1:0] DEPTH_CNT = 5'h10;
	localparam logic [CNT_W-1:0] AF_OFFSET_RST = 5'h02;

	// units per word, as a log2 code
	localparam logic [1:0] LOG_X36 = 2'h0;
	localparam logic [1:0] LOG_X18 = 2'h1;
	localparam logic [1:0] LOG_X9 = 2'h2;

	// avalon byte offsets
	localparam logic [3:0] REG_CONFIG = 4'h0;
	localparam logic [3:0] REG_AF_OFFSET = 4'h4;
	localparam logic [3:0] REG_LEVELS = 4'h8;
	localparam logic [3:0] REG_PORT_STATUS = 4'hC;

	// flag bus ownership mode latched at master reset
	localparam logic FM_DIRECT = 1'b0;
	localparam logic FM_POLLED = 1'b1;

	typedef enum logic [1:0] {
		RS_QUEUE = 2'b01,
		RS_NULL = 2'b10
	} mqpa_rsel_e;
endpackage

// File: hdl/mqpa_store_if.sv
`timescale 1ns/1ps
interface mqpa_store_if;
	import mqpa_pkg::*;
	logic push;
	logic [QW-1:0] push_q;
	logic [DATA_W-1:0] push_data;
	logic pop;
	logic [QW-1:0] pop_q;
	logic [DATA_W-1:0] pop_data;
	logic [CNT_W-1:0] level [QN];

	modport owner (output push, output push_q, output push_data, output pop, output pop_q,
		input pop_data, input level);
	modport store (input push, input push_q, input push_data, input pop, input pop_q,
		output pop_data, output level);
endinterface

// File: hdl/mqpa_queue_store.sv
`timescale 1ns/1ps
module mqpa_queue_store
	import mqpa_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	mqpa_store_if.store sif
);
	logic [DATA_W-1:0] mem [QN*DEPTH];
	logic [PTR_W-1:0] rptr [QN];
	logic [PTR_W-1:0] wptr [QN];

	// whole 36-bit word stored, marker and modulo bits untouched
	assign sif.pop_data = mem[{sif.pop_q, rptr[sif.pop_q]}];

	// one write process for the shared array, so it keeps a single driver
	always_ff @(posedge clk) begin
		if (sif.push) begin
			mem[{sif.push_q, wptr[sif.push_q]}] <= sif.push_data;
		end
	end

	genvar g;
	generate
		for (g = 0; g < QN; g++) begin : g_queue
			logic do_push;
			logic do_pop;
			assign do_push = sif.push && (sif.push_q == QW'(g));
			assign do_pop = sif.pop && (sif.pop_q == QW'(g));

			always_ff @(posedge clk) begin
				if (sys_rst) begin
					wptr[g] <= '0;
					rptr[g] <= '0;
					sif.level[g] <= '0;
				end else begin
					if (do_push) begin
						wptr[g] <= wptr[g] + 4'h1;
					end
					if (do_pop) begin
						rptr[g] <= rptr[g] + 4'h1;
					end
					if (do_push && !do_pop) begin
						sif.level[g] <= sif.level[g] + 5'h01;
					end else if (do_pop && !do_push) begin
						sif.level[g] <= sif.level[g] - 5'h01;
					end
				end
			end
		end
	endgenerate
endmodule // mqpa_queue_store

// File: hdl/mqpa_flag_bus.sv
`timescale 1ns/1ps
module mqpa_flag_bus
	import mqpa_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic mode,
	input wire logic [ID_W-1:0] chip_id,
	input wire logic strobe,
	input wire logic [ID_W-1:0] strobe_id,
	input wire logic [QN-1:0] almost_full,
	output logic [QN-1:0] bus_n,
	output logic bus_oe
);
	logic [ID_W-1:0] poll_slot;

	// polled mode: ownership walks all eight device codes, one clock each
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			poll_slot <= '0;
		end else begin
			poll_slot <= poll_slot + 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bus_oe <= 1'b0;
		end else if (mode == FM_POLLED) begin
			bus_oe <= (poll_slot == chip_id);
		end else if (strobe) begin
			bus_oe <= (strobe_id == chip_id);
		end
	end

	// bit k reports queue k+1, low means almost full
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bus_n <= {QN{1'b1}};
		end else begin
			bus_n <= ~almost_full;
		end
	end
endmodule // mqpa_flag_bus

// File: hdl/mqpa_top.sv
// Behaviour
// - modulo marker bits are payload only; no logic reads them.
// - bits 32 and 33 are stored and returned unchanged with their word.
// - a word can leave the read port every clock, even across queue switches.
// - the read pipeline keeps fetching the next words of the selected queue.
// - when a queue empties, its last word still reaches the output register.
// - read address bit 2 set selects the null queue.
// - after a null switch, pipeline data of the old queue still drains out.
// - null queue is always empty; last word holds, output-valid goes high.
// - null queue works in both modes and does nothing on the write port.
// - full and almost-full pins follow the write-selected queue only.
// - four-bit almost-full bus, queue one on bit zero to queue four on bit three.
// - one device drives the shared flag bus; direct or polled, latched at reset.
// - write address: low two bits pick queue, upper three pick the device.
// - device writes only when upper write-address bits equal its chip code.
// - in direct mode write address plus strobe picks the flag bus owner.
// - widths latched at reset from width match, input and output selects.
// - narrow units are packed into a 36-bit word little-endian.
// - full flags count in whole 36-bit words, not write-width units.
// - output-valid counts in read-width units.
// - every queue shares the same input width and output width.
//
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module mqpa_top
	import mqpa_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [DATA_W-1:0] data_in,
	input wire logic write_enable,
	input wire logic write_address_enable,
	input wire logic [WADDR_W-1:0] write_queue_address,
	input wire logic read_enable,
	input wire logic read_address_enable,
	input wire logic [RADDR_W-1:0] read_queue_address,
	input wire logic almost_full_bus_strobe,
	input wire logic flag_bus_select_mode,
	input wire logic chip_select_code_bit0,
	input wire logic chip_select_code_bit1,
	input wire logic chip_select_code_bit2,
	input wire logic width_match_enable,
	input wire logic input_width_select,
	input wire logic output_width_select,
	output logic [DATA_W-1:0] data_out,
	output logic output_valid_flag_n,
	output logic active_queue_full_flag_n,
	output logic active_queue_full_flag_oe,
	output logic active_almost_full_flag_n,
	output logic [QN-1:0] almost_full_flag_bus_n,
	output logic almost_full_flag_bus_oe
);
	mqpa_store_if sif ();

	logic cfg_fm;
	logic [ID_W-1:0] cfg_id;
	logic cfg_bm;
	logic cfg_iw;
	logic cfg_ow;
	logic [1:0] wr_log;
	logic [1:0] rd_log;
	logic [CNT_W-1:0] af_offset;

	logic [QW-1:0] wr_sel;
	logic wr_selected;
	logic [1:0] pack_idx;
	logic [DATA_W-1:0] pack_word;
	logic wr_take;
	logic wr_last;
	logic [DATA_W-1:0] next_pack_word;

	mqpa_rsel_e rd_state;
	logic [QW-1:0] rd_sel;
	logic pipe_valid;
	logic [DATA_W-1:0] pipe_word;
	logic [1:0] unit_idx;
	logic out_need;
	logic pipe_pop;
	logic fetch;
	logic [QN-1:0] q_almost_full;
	logic [QN-1:0] q_full;
	logic rd_last_unit;
	logic af_wr_hit;

	// packs unit idx of a narrow write into the word, lowest unit first
	function automatic logic [DATA_W-1:0] put_unit(input logic [DATA_W-1:0] w, input logic [DATA_W-1:0] d,
		input logic [1:0] lg, input logic [1:0] idx);
		logic [DATA_W-1:0] r;
		r = w;
		case (lg)
			LOG_X18: begin
				if (idx[0]) begin
					r[DATA_W-1:UNIT18_W] = d[UNIT18_W-1:0];
				end else begin
					r[UNIT18_W-1:0] = d[UNIT18_W-1:0];
				end
			end
			LOG_X9: begin
				r[idx*UNIT9_W +: UNIT9_W] = d[UNIT9_W-1:0];
			end
			default: begin
				r = d;
			end
		endcase
		return r;
	endfunction

	// picks unit idx of a word for a narrow read, zero above the unit
	function automatic logic [DATA_W-1:0] get_unit(input logic [DATA_W-1:0] w, input logic [1:0] lg,
		input logic [1:0] idx);
		logic [DATA_W-1:0] r;
		r = '0;
		case (lg)
			LOG_X18: begin
				r[UNIT18_W-1:0] = w[idx[0]*UNIT18_W +: UNIT18_W];
			end
			LOG_X9: begin
				r[UNIT9_W-1:0] = w[idx*UNIT9_W +: UNIT9_W];
			end
			default: begin
				r = w;
			end
		endcase
		return r;
	endfunction

	// setup pins are sampled only while master reset is held
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_fm <= flag_bus_select_mode;
			cfg_id <= {chip_select_code_bit2, chip_select_code_bit1, chip_select_code_bit0};
			cfg_bm <= width_match_enable;
			cfg_iw <= input_width_select;
			cfg_ow <= output_width_select;
		end
	end

	// one width per port, shared by every queue
	always_comb begin
		wr_log = LOG_X36;
		rd_log = LOG_X36;
		// bus matching always keeps one side at x36
		if (cfg_bm) begin
			case ({cfg_iw, cfg_ow})
				2'b00: rd_log = LOG_X18;
				2'b01: rd_log = LOG_X9;
				2'b10: wr_log = LOG_X18;
				2'b11: wr_log = LOG_X9;
				default: rd_log = LOG_X36;
			endcase
		end
	end

	// write side

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_sel <= '0;
			wr_selected <= 1'b0;
		end else if (write_address_enable) begin
			wr_sel <= write_queue_address[QW-1:0];
			wr_selected <= (write_queue_address[WADDR_W-1:QW] == cfg_id);
		end
	end

	genvar g;
	generate
		for (g = 0; g < QN; g++) begin : g_flags
			// a word slot is only spent once a whole write-width set is in
			assign q_full[g] = (sif.level[g] == DEPTH_CNT);
			assign q_almost_full[g] = (sif.level[g] >= (DEPTH_CNT - af_offset));
		end
	endgenerate

	assign wr_take = write_enable && wr_selected && !q_full[wr_sel];
	assign wr_last = (pack_idx == ((2'h1 << wr_log) - 2'h1));
	assign next_pack_word = put_unit(pack_word, data_in, wr_log, pack_idx);

	// partial word is dropped if the write queue changes mid-word
	always_ff @(posedge clk) begin
		if (sys_rst || write_address_enable) begin
			pack_idx <= '0;
			pack_word <= '0;
		end else if (wr_take) begin
			pack_word <= next_pack_word;
			pack_idx <= wr_last ? 2'h0 : pack_idx + 2'h1;
		end
	end

	assign sif.push = wr_take && wr_last;
	assign sif.push_q = wr_sel;
	assign sif.push_data = next_pack_word;

	// flags track the selected queue, one clock after selection
	// full pin idles high while another device owns the shared line
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			active_queue_full_flag_n <= 1'b1;
		end else begin
			active_queue_full_flag_n <= !(q_full[wr_sel] && wr_selected);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			active_almost_full_flag_n <= 1'b1;
		end else begin
			active_almost_full_flag_n <= !q_almost_full[wr_sel];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			active_queue_full_flag_oe <= 1'b0;
		end else begin
			active_queue_full_flag_oe <= wr_selected;
		end
	end

	mqpa_flag_bus u_flag_bus (
		.clk(clk),
		.sys_rst(sys_rst),
		.mode(cfg_fm),
		.chip_id(cfg_id),
		.strobe(almost_full_bus_strobe),
		.strobe_id(write_queue_address[WADDR_W-1:QW]),
		.almost_full(q_almost_full),
		.bus_n(almost_full_flag_bus_n),
		.bus_oe(almost_full_flag_bus_oe)
	);

	// read side

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_state <= RS_NULL;
			rd_sel <= '0;
		end else if (read_address_enable) begin
			rd_sel <= read_queue_address[QW-1:0];
			if (read_queue_address[RADDR_NULL_BIT]) begin
				rd_state <= RS_NULL;
			end else begin
				rd_state <= RS_QUEUE;
			end
		end
	end

	assign out_need = output_valid_flag_n || read_enable;
	// the shift wraps to zero for x9, leaving three as the last unit index
	assign rd_last_unit = (unit_idx == ((2'h1 << rd_log) - 2'h1));
	assign pipe_pop = out_need && pipe_valid && rd_last_unit;

	// prefetch keeps the stage full so reads stay back to back
	always_comb begin
		case (rd_state)
			RS_QUEUE: fetch = (sif.level[rd_sel] != '0) && (!pipe_valid || pipe_pop);
			RS_NULL: fetch = 1'b0;
			default: fetch = 1'b0;
		endcase
	end

	assign sif.pop = fetch;
	assign sif.pop_q = rd_sel;

	// stage drains regardless of the queue now selected
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pipe_valid <= 1'b0;
			pipe_word <= '0;
		end else if (fetch) begin
			pipe_valid <= 1'b1;
			pipe_word <= sif.pop_data;
		end else if (pipe_pop) begin
			pipe_valid <= 1'b0;
		end
	end

	// output register: hold last word, flag high when nothing follows
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			data_out <= '0;
			output_valid_flag_n <= 1'b1;
			unit_idx <= '0;
		end else if (out_need) begin
			if (pipe_valid) begin
				data_out <= get_unit(pipe_word, rd_log, unit_idx);
				output_valid_flag_n <= 1'b0;
				unit_idx <= pipe_pop ? 2'h0 : unit_idx + 2'h1;
			end else begin
				output_valid_flag_n <= 1'b1;
			end
		end
	end

	// register slave: waitrequest drops for one clock per access

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// lane 0 carries the whole offset field
	assign af_wr_hit = avs_write && !avs_waitrequest && avs_address == REG_AF_OFFSET && avs_byteenable[0];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			af_offset <= AF_OFFSET_RST;
		end else if (af_wr_hit) begin
			af_offset <= avs_writedata[CNT_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			avs_readdata <= '0;
		end else if (avs_read && avs_waitrequest) begin
			case (avs_address)
				REG_CONFIG: avs_readdata <= {25'h0, cfg_id, cfg_fm, cfg_ow, cfg_iw, cfg_bm};
				REG_AF_OFFSET: avs_readdata <= {27'h0, af_offset};
				REG_LEVELS: avs_readdata <= {3'h0, sif.level[3], 3'h0, sif.level[2], 3'h0, sif.level[1],
					3'h0, sif.level[0]};
				REG_PORT_STATUS: avs_readdata <= {24'h0, pipe_valid, output_valid_flag_n, rd_state == RS_NULL,
					rd_sel, wr_selected, wr_sel};
				default: avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	mqpa_queue_store u_store (
		.clk(clk),
		.sys_rst(sys_rst),
		.sif(sif.store)
	);
endmodule // mqpa_top

// File: test/mqpa_monitor.sv
`timescale 1ns/1ps
module mqpa_monitor
	import mqpa_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic write_address_enable,
	input wire logic [WADDR_W-1:0] write_queue_address,
	input wire logic read_enable,
	input wire logic read_address_enable,
	input wire logic [RADDR_W-1:0] read_queue_address,
	input wire logic almost_full_bus_strobe,
	input wire logic flag_bus_select_mode,
	input wire logic chip_select_code_bit0,
	input wire logic chip_select_code_bit1,
	input wire logic chip_select_code_bit2,
	input wire logic [DATA_W-1:0] data_out,
	input wire logic output_valid_flag_n,
	input wire logic active_queue_full_flag_n,
	input wire logic active_queue_full_flag_oe,
	input wire logic active_almost_full_flag_n,
	input wire logic almost_full_flag_bus_oe
);
	logic [ID_W-1:0] cid;
	assign cid = {chip_select_code_bit2, chip_select_code_bit1, chip_select_code_bit0};
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_null;
		read_address_enable && read_queue_address[RADDR_NULL_BIT] ##1 (!read_address_enable && read_enable) [*4];
	endsequence
	sequence s_wsel;
		write_address_enable ##1 !write_address_enable [*2];
	endsequence
	property p_null; s_null |=> output_valid_flag_n; endproperty
	property p_hold;
		!output_valid_flag_n && !read_enable && !read_address_enable |=> $stable(data_out) && !output_valid_flag_n;
	endproperty
	property p_wsel; s_wsel |-> active_queue_full_flag_oe == ($past(write_queue_address[4:2], 2) == cid); endproperty
	property p_polled;
		flag_bus_select_mode == FM_POLLED && almost_full_flag_bus_oe |=>
			!almost_full_flag_bus_oe [*7] ##1 almost_full_flag_bus_oe;
	endproperty
	property p_direct;
		almost_full_bus_strobe && flag_bus_select_mode == FM_DIRECT |=>
			almost_full_flag_bus_oe == ($past(write_queue_address[4:2]) == cid);
	endproperty
	property p_full; !active_queue_full_flag_n |-> !active_almost_full_flag_n; endproperty
	property p_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest; endproperty
	property p_oe_fullpin; !active_queue_full_flag_oe |-> active_queue_full_flag_n; endproperty
	a_null: assert property (p_null) else $error("null queue left output valid");
	a_hold: assert property (p_hold) else $error("unread output word changed");
	a_wsel: assert property (p_wsel) else $error("full flag drive wrong for chip code");
	a_polled: assert property (p_polled) else $error("polled flag bus slot wrong");
	a_direct: assert property (p_direct) else $error("direct flag bus owner wrong");
	a_full: assert property (p_full) else $error("full without almost full");
	a_ans: assert property (p_ans) else $error("bus answer timing wrong");
	a_oe_fullpin: assert property (p_oe_fullpin) else $error("full shown while not selected");
endmodule // mqpa_monitor
bind mqpa_top mqpa_monitor u_mon (.*);

// File: test/mqpa_ctrl_model.sv
`timescale 1ns/1ps
module mqpa_ctrl_model
	import mqpa_pkg::*;
(
	input wire logic clk,
	input wire logic [DATA_W-1:0] data_out,
	input wire logic output_valid_flag_n,
	output logic [DATA_W-1:0] data_in,
	output logic write_enable,
	output logic write_address_enable,
	output logic [WADDR_W-1:0] write_queue_address,
	output logic read_enable,
	output logic read_address_enable,
	output logic [RADDR_W-1:0] read_queue_address
);
	logic [DATA_W-1:0] got [4];
	int n_got;
	initial begin
		data_in = '0;
		write_enable = 1'b0;
		write_address_enable = 1'b0;
		write_queue_address = '0;
		read_enable = 1'b0;
		read_address_enable = 1'b0;
		read_queue_address = '0;
	end
	task wsel(input logic [WADDR_W-1:0] a);
		write_address_enable <= 1'b1;
		write_queue_address <= a;
		@(posedge clk);
		write_address_enable <= 1'b0;
	endtask
	task rsel(input logic [RADDR_W-1:0] a);
		read_address_enable <= 1'b1;
		read_queue_address <= a;
		@(posedge clk);
		read_address_enable <= 1'b0;
	endtask
	task put(input logic [DATA_W-1:0] d, input logic last);
		write_enable <= 1'b1;
		data_in <= d;
		@(posedge clk);
		if (last) begin
			write_enable <= 1'b0;
			// released bus shows a changed pattern, not the old word
			data_in <= ~d;
		end
	endtask
	// keeps read_enable high for the whole wait, so empty cycles test refusal
	task get(input int n);
		n_got = 0;
		read_enable <= 1'b1;
		for (int t = 0; t < 12 && n_got < n; t++) begin
			@(posedge clk);
			if (output_valid_flag_n === 1'b0) begin
				got[n_got] = data_out;
				n_got++;
			end
		end
		read_enable <= 1'b0;
	endtask
endmodule // mqpa_ctrl_model

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
	import mqpa_pkg::*;
	localparam logic [2:0] MY_ID = 3'h5;
	logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, write_enable, write_address_enable;
	logic [3:0] avs_address, avs_byteenable, almost_full_flag_bus_n;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [DATA_W-1:0] data_in, data_out;
	logic [WADDR_W-1:0] write_queue_address;
	logic [RADDR_W-1:0] read_queue_address;
	logic read_enable, read_address_enable, almost_full_bus_strobe, flag_bus_select_mode;
	logic chip_select_code_bit0, chip_select_code_bit1, chip_select_code_bit2;
	logic width_match_enable, input_width_select, output_width_select, output_valid_flag_n;
	logic active_queue_full_flag_n, active_queue_full_flag_oe, active_almost_full_flag_n, almost_full_flag_bus_oe;
	int mismatches = 0;
	int n_checks = 0;
	logic [2:0] my_id = MY_ID;
	assign {chip_select_code_bit2, chip_select_code_bit1, chip_select_code_bit0} = my_id;
	mqpa_ctrl_model ctl (.*);
	mqpa_top DUT (.*);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task av(input logic [3:0] a, input logic w, input logic [31:0] d);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= d;
		// no cycle count assumed; the watchdog ends a hung access
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask
	task rst(input logic f, input logic b, input logic i, input logic o);
		sys_rst <= 1'b1;
		flag_bus_select_mode <= f;
		width_match_enable <= b;
		input_width_select <= i;
		output_width_select <= o;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
	endtask
	task strobe;
		almost_full_bus_strobe <= 1'b1;
		@(posedge clk);
		almost_full_bus_strobe <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task t_regs;
		av(REG_CONFIG, 1'b0, 32'h0); chk(rd, 32'h50);
		av(REG_AF_OFFSET, 1'b0, 32'h0); chk(rd, 32'h2);
		av(REG_AF_OFFSET, 1'b1, 32'hE);
		av(REG_AF_OFFSET, 1'b0, 32'h0); chk(rd, 32'hE);
		av(4'h2, 1'b0, 32'h0); chk(rd, 32'h0);
		$display("test regs done");
	endtask
	task t_pass;
		ctl.wsel({MY_ID, 2'h1});
		ctl.put(36'hA12345678, 1'b0);
		ctl.put(36'h59ABCDEF0, 1'b0);
		ctl.put(36'hF0F0F0F0F, 1'b1);
		strobe();
		chk(almost_full_flag_bus_oe, 1'b1);
		chk(almost_full_flag_bus_n, 4'hD);
		chk(active_almost_full_flag_n, 1'b0);
		ctl.rsel(6'h01);
		ctl.get(3);
		chk(ctl.got[0], 36'hA12345678);
		chk(ctl.got[1], 36'h59ABCDEF0);
		chk(ctl.got[2], 36'hF0F0F0F0F);
		$display("test pass-through done");
	endtask
	task t_null;
		ctl.wsel({MY_ID, 2'h0});
		ctl.put(36'h3CAFE0001, 1'b0);
		ctl.put(36'hCBEEF0002, 1'b1);
		ctl.rsel(6'h00);
		ctl.get(1);
		chk(ctl.got[0], 36'h3CAFE0001);
		ctl.rsel(6'h3C);
		ctl.get(2);
		chk(ctl.n_got, 36'h1);
		chk(ctl.got[0], 36'hCBEEF0002);
		chk(data_out, 36'hCBEEF0002);
		chk(output_valid_flag_n, 1'b1);
		av(REG_PORT_STATUS, 1'b0, 32'h0); chk(rd, 32'h64);
		$display("test null queue done");
	endtask
	task t_fill;
		ctl.wsel({3'h2, 2'h0});
		ctl.put(36'h1, 1'b1);
		strobe();
		chk(active_queue_full_flag_oe, 1'b0);
		chk(almost_full_flag_bus_oe, 1'b0);
		ctl.wsel({MY_ID, 2'h3});
		for (int k = 0; k < 16; k++)
			ctl.put(36'(k), 1'b0);
		ctl.put(36'hFF, 1'b1);
		repeat (3) @(posedge clk);
		chk(active_queue_full_flag_n, 1'b0);
		chk(active_queue_full_flag_oe, 1'b1);
		av(REG_LEVELS, 1'b0, 32'h0); chk(rd, 32'h10000000);
		$display("test fill done");
	endtask
	task t_bm;
		rst(1'b1, 1'b1, 1'b1, 1'b0);
		av(REG_CONFIG, 1'b0, 32'h0); chk(rd, 32'h5B);
		ctl.wsel({MY_ID, 2'h2});
		ctl.put(36'h21111, 1'b0);
		ctl.put(36'h32222, 1'b1);
		ctl.rsel(6'h02);
		ctl.get(1);
		chk(ctl.got[0], {18'h32222, 18'h21111});
		$display("test bus matching done");
	endtask
	task t_x9;
		my_id <= 3'h6;
		rst(1'b0, 1'b1, 1'b0, 1'b1);
		av(REG_CONFIG, 1'b0, 32'h0); chk(rd, 32'h65);
		avs_byteenable <= 4'hE;
		av(REG_AF_OFFSET, 1'b1, 32'h9);
		avs_byteenable <= 4'hF;
		av(REG_AF_OFFSET, 1'b0, 32'h0); chk(rd, 32'h2);
		ctl.wsel({3'h6, 2'h1});
		ctl.put({9'h144, 9'h133, 9'h122, 9'h111}, 1'b1);
		ctl.rsel(6'h01);
		ctl.get(4);
		chk(ctl.n_got, 36'h4);
		chk(ctl.got[0], 36'h111);
		chk(ctl.got[1], 36'h122);
		chk(ctl.got[2], 36'h133);
		chk(ctl.got[3], 36'h144);
		$display("test narrow read done");
	endtask
	initial begin
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		almost_full_bus_strobe = 1'b0;
		rst(1'b0, 1'b0, 1'b0, 1'b0);
		t_regs();
		t_pass();
		t_null();
		t_fill();
		t_bm();
		t_x9();
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		complete_run();
	end
endmodule // testbench
